// ==== rtl/lmc_defs.svh ====
// Constants for the logger mission-control command block.
// Assumes a 50 MHz clock; included by its bare name.
`ifndef LMC_DEFS_SVH
`define LMC_DEFS_SVH
`define LMC_CMD_CLEAR 8'h96
`define LMC_CMD_CONV 8'h55
`define LMC_CMD_START 8'hCC
`define LMC_CMD_STOP 8'h33
`define LMC_DUMMY_BYTE 8'hFF
`define LMC_ALL_ONES 8'hFF
`define LMC_GS_ADDR 16'h0215
`define LMC_GS_MIP_BIT 1
`define LMC_GS_MEMORY_CLEARED_FLAG_BIT 3
`define LMC_GS_WAITING_FOR_ALARM_FLAG_BIT 4
`define LMC_GS_RSVD 8'hE5
`define LMC_PWD_BYTES 4'h8
`define LMC_CLK_HZ 50000000
`define LMC_CONV_MS 666
`define LMC_CONV_CYCLES (`LMC_CONV_MS * (`LMC_CLK_HZ / 1000))
`define LMC_SEC_CYCLES `LMC_CLK_HZ
`endif

// ==== rtl/lmc_pkg.sv ====
// Types for the logger mission-control command block.
// Assumes lmc_defs.svh holds all numeric constants.
package lmc_pkg;
   typedef enum logic [4:0] {
      CS_IDLE = 5'h01,
      CS_PWD = 5'h02,
      CS_DUMMY = 5'h04,
      CS_SILENT = 5'h08,
      CS_SKIP = 5'h10
   } lmc_cmd_e;
   typedef enum logic [4:0] {
      MS_OFF = 5'h01,
      MS_DELAY = 5'h02,
      MS_ALARM = 5'h04,
      MS_FIRST = 5'h08,
      MS_LOG = 5'h10
   } lmc_mission_e;
   typedef struct packed {
      lmc_cmd_e cmd;
      lmc_mission_e mission;
      logic [7:0] code;
      logic mission_running_flag;
      logic memory_cleared_flag;
      logic waiting_for_alarm_flag;
      logic auth_accepted_flag;
      logic silent;
      logic session;
      logic interfere;
      logic busy;
      logic forced;
      logic [24:0] conv_cnt;
      logic [15:0] period_cnt;
      logic [15:0] temp;
      logic [15:0] hum;
      logic [7:0] gs;
      logic regwr;
      logic clear_log;
      logic sensor_start;
      logic count_inc;
      logic log_first;
      logic ts_set;
      logic copy_go;
   } lmc_state_s;
   typedef struct packed {
      logic [63:0] sh;
      logic [3:0] cnt;
   } lmc_pwd_s;
   typedef struct packed {
      logic [25:0] cnt;
      logic tick;
   } lmc_tick_s;
endpackage

// ==== rtl/lmc_sec_tick.sv ====
// One-second timebase for mission delay and sample period counting.
// Assumes the 50 MHz system clock.
`timescale 1ns/1ns
`include "lmc_defs.svh"
module lmc_sec_tick #(
   parameter int unsigned SEC_CYCLES = `LMC_SEC_CYCLES
) (
   input wire logic clk_in,
   input wire logic rst_in,
   output logic tick_out
);
   lmc_pkg::lmc_tick_s r_reg;
   lmc_pkg::lmc_tick_s r_next;
   always_comb begin
      r_next = r_reg;
      r_next.tick = 1'b0;
      if (r_reg.cnt == 26'(SEC_CYCLES - 1)) begin
         r_next.cnt = 26'h0;
         r_next.tick = 1'b1;
      end else begin
         r_next.cnt = r_reg.cnt + 26'h1;
      end
   end
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end
   assign tick_out = r_reg.tick;
endmodule

// ==== rtl/lmc_pwd_match.sv ====
// Collects the eight password bytes, first byte lowest, and compares them.
// Assumes bytes arrive as one-cycle strobes.
`timescale 1ns/1ns
`include "lmc_defs.svh"
module lmc_pwd_match (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic clear_in,
   input wire logic byte_valid_in,
   input wire logic [7:0] byte_in,
   input wire logic enable_in,
   input wire logic [63:0] stored_in,
   output logic [3:0] count_out,
   output logic ok_out
);
   lmc_pkg::lmc_pwd_s r_reg;
   lmc_pkg::lmc_pwd_s r_next;
   always_comb begin
      r_next = r_reg;
      if (clear_in) begin
         r_next.cnt = 4'h0;
      end else if (byte_valid_in && r_reg.cnt != `LMC_PWD_BYTES) begin
         r_next.sh = {byte_in, r_reg.sh[63:8]};
         r_next.cnt = r_reg.cnt + 4'h1;
      end
   end
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end
   assign count_out = r_reg.cnt;
   assign ok_out = !enable_in || (r_reg.sh == stored_in);
endmodule

// ==== rtl/lmc_ctrl.sv ====
// Mission-control command handler of the logger: memory clear, forced
// conversion, mission start and stop, sampling and access conflicts.
// Assumes a byte-level front end that strips bus reset, ROM selection
// and bit timing, and a sensor that reports sensor_done_in.
// Overview of operation
// - Memory clear runs only while no mission is running.
// - Clear fails on wrong password or running mission; device silent until reset.
// - Successful clear zeroes timestamp, sample counter and all alarm flags.
// - After the clear, the memory-cleared flag reads one.
// - Clear leaves the data-log memory untouched; counter marks valid entries.
// - Forced conversion starts after the all-ones byte following its code.
// - Conversion results land as 16-bit temperature and humidity values.
// - Forced conversion runs only while no mission is running.
// - Forced conversion is uninterruptible, at most 666 ms, blocking host access.
// - New mission starts only after previous ended and memory cleared.
// - Start fails on wrong password or running mission; device silent.
// - With alarm start off, sampling begins when the start delay elapses.
// - With alarm start on, first sample uncounted; timestamp one period later.
// - Waiting-for-alarm flag reads one while waiting for the alarm.
// - During a mission register pages are read only.
// - Stop fails on wrong password or no mission running; device silent.
// - Stop clears mission-running, restores page writes, keeps waiting flag.
// - Sampling takes priority over host commands; ROM commands and reset unaffected.
// - Interfered scratchpad write returns an all-ones CRC.
// - Interfered reads return all-ones bytes from then on, CRC included.
// - Interfered stop shows status all ones; host waits, retries, checks.
// - Matching copy pattern sets the auth-accepted flag and performs the copy.
`timescale 1ns/1ns
`include "lmc_defs.svh"
module lmc_ctrl #(
   parameter int unsigned CONV_CYCLES = `LMC_CONV_CYCLES,
   parameter int unsigned SEC_CYCLES = `LMC_SEC_CYCLES
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic bus_reset_in,
   input wire logic fn_byte_valid_in,
   input wire logic fn_first_in,
   input wire logic [7:0] fn_byte_in,
   input wire logic pw_enable_in,
   input wire logic [63:0] pw_full_in,
   input wire logic start_on_temp_alarm_in,
   input wire logic [15:0] start_delay_in,
   input wire logic [15:0] sample_period_in,
   input wire logic temp_alarm_in,
   input wire logic sensor_done_in,
   input wire logic [15:0] temp_data_in,
   input wire logic [15:0] hum_data_in,
   input wire logic copy_req_in,
   input wire logic copy_match_in,
   input wire logic copy_reg_page_in,
   input wire logic write_scratch_in,
   output logic [7:0] general_status_out,
   output logic silent_out,
   output logic force_ones_out,
   output logic comm_blocked_out,
   output logic reg_write_en_out,
   output logic clear_log_out,
   output logic sensor_start_out,
   output logic sample_count_inc_out,
   output logic log_first_out,
   output logic timestamp_set_out,
   output logic [15:0] temp_result_out,
   output logic [15:0] hum_result_out,
   output logic auth_accepted_flag_out,
   output logic copy_go_out
);
   lmc_pkg::lmc_state_s r_reg;
   lmc_pkg::lmc_state_s r_next;
   logic tick;
   logic [3:0] pwd_cnt;
   logic pwd_ok;
   logic pwd_clear;
   logic pwd_take;

   assign pwd_clear = (r_reg.cmd == lmc_pkg::CS_IDLE);
   assign pwd_take = fn_byte_valid_in && (r_reg.cmd == lmc_pkg::CS_PWD);

   lmc_sec_tick #(
      .SEC_CYCLES(SEC_CYCLES)
   ) u_tick (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .tick_out(tick)
   );

   lmc_pwd_match u_pwd (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .clear_in(pwd_clear),
      .byte_valid_in(pwd_take),
      .byte_in(fn_byte_in),
      .enable_in(pw_enable_in),
      .stored_in(pw_full_in),
      .count_out(pwd_cnt),
      .ok_out(pwd_ok)
   );

   always_comb begin
      logic start_samp;
      logic go_silent;
      logic period_end;
      start_samp = 1'b0;
      go_silent = 1'b0;
      period_end = (r_reg.period_cnt + 16'h1) >= sample_period_in;
      r_next = r_reg;
      r_next.clear_log = 1'b0;
      r_next.sensor_start = 1'b0;
      r_next.count_inc = 1'b0;
      r_next.log_first = 1'b0;
      r_next.ts_set = 1'b0;
      r_next.copy_go = 1'b0;

      // Mission timing runs on the one-second tick.
      case (r_reg.mission)
         lmc_pkg::MS_DELAY: begin
            if (tick) begin
               if (r_reg.period_cnt >= start_delay_in) begin
                  r_next.mission = lmc_pkg::MS_LOG;
                  r_next.period_cnt = 16'h0;
                  r_next.ts_set = 1'b1;
                  r_next.count_inc = 1'b1;
                  start_samp = 1'b1;
               end else begin
                  r_next.period_cnt = r_reg.period_cnt + 16'h1;
               end
            end
         end
         lmc_pkg::MS_ALARM: begin
            if (temp_alarm_in) begin
               r_next.mission = lmc_pkg::MS_FIRST;
               r_next.waiting_for_alarm_flag = 1'b0;
               r_next.period_cnt = 16'h0;
               r_next.log_first = 1'b1;
               start_samp = 1'b1;
            end
         end
         lmc_pkg::MS_FIRST: begin
            if (tick) begin
               if (period_end) begin
                  r_next.mission = lmc_pkg::MS_LOG;
                  r_next.period_cnt = 16'h0;
                  r_next.ts_set = 1'b1;
                  r_next.count_inc = 1'b1;
                  start_samp = 1'b1;
               end else begin
                  r_next.period_cnt = r_reg.period_cnt + 16'h1;
               end
            end
         end
         lmc_pkg::MS_LOG: begin
            if (tick) begin
               if (period_end) begin
                  r_next.period_cnt = 16'h0;
                  r_next.count_inc = 1'b1;
                  start_samp = 1'b1;
               end else begin
                  r_next.period_cnt = r_reg.period_cnt + 16'h1;
               end
            end
         end
         default: begin
         end
      endcase

      // A running conversion ends on the sensor's done or at the time limit.
      if (r_reg.busy) begin
         r_next.conv_cnt = r_reg.conv_cnt + 25'h1;
         if (sensor_done_in) begin
            r_next.temp = temp_data_in;
            r_next.hum = hum_data_in;
         end
         if (sensor_done_in || r_reg.conv_cnt == 25'(CONV_CYCLES - 1)) begin
            r_next.busy = 1'b0;
            r_next.forced = 1'b0;
         end
      end
      if (start_samp && !r_reg.busy) begin
         r_next.busy = 1'b1;
         r_next.sensor_start = 1'b1;
         r_next.conv_cnt = 25'h0;
      end

      // Command sequencing; the log memory itself is never erased.
      if (bus_reset_in) begin
         r_next.cmd = lmc_pkg::CS_IDLE;
         r_next.silent = 1'b0;
         r_next.session = 1'b0;
         r_next.interfere = 1'b0;
      end else begin
         if (fn_byte_valid_in && fn_first_in) begin
            r_next.session = 1'b1;
         end
         if (r_reg.busy && (r_reg.session || fn_byte_valid_in)) begin
            r_next.interfere = 1'b1;
         end
         case (r_reg.cmd)
            lmc_pkg::CS_IDLE: begin
               if (fn_byte_valid_in && fn_first_in) begin
                  r_next.code = fn_byte_in;
                  if (fn_byte_in == `LMC_CMD_CONV) begin
                     r_next.cmd = lmc_pkg::CS_DUMMY;
                  end else if (fn_byte_in == `LMC_CMD_CLEAR ||
                               fn_byte_in == `LMC_CMD_START ||
                               fn_byte_in == `LMC_CMD_STOP) begin
                     r_next.cmd = lmc_pkg::CS_PWD;
                  end else begin
                     r_next.cmd = lmc_pkg::CS_SKIP;
                  end
               end
            end
            lmc_pkg::CS_PWD: begin
               if (pwd_cnt == `LMC_PWD_BYTES) begin
                  r_next.cmd = lmc_pkg::CS_DUMMY;
               end
            end
            lmc_pkg::CS_DUMMY: begin
               if (fn_byte_valid_in) begin
                  r_next.cmd = lmc_pkg::CS_SKIP;
                  if (r_reg.code == `LMC_CMD_CLEAR) begin
                     if (!pwd_ok || r_reg.mission_running_flag) begin
                        go_silent = 1'b1;
                     end else begin
                        r_next.clear_log = 1'b1;
                        r_next.memory_cleared_flag = 1'b1;
                        r_next.waiting_for_alarm_flag = 1'b0;
                     end
                  end else if (r_reg.code == `LMC_CMD_START) begin
                     if (!pwd_ok || r_reg.mission_running_flag ||
                         !r_reg.memory_cleared_flag) begin
                        go_silent = 1'b1;
                     end else begin
                        r_next.mission_running_flag = 1'b1;
                        r_next.memory_cleared_flag = 1'b0;
                        r_next.period_cnt = 16'h0;
                        if (start_on_temp_alarm_in) begin
                           r_next.mission = lmc_pkg::MS_ALARM;
                           r_next.waiting_for_alarm_flag = 1'b1;
                        end else begin
                           r_next.mission = lmc_pkg::MS_DELAY;
                        end
                     end
                  end else if (r_reg.code == `LMC_CMD_STOP) begin
                     if (r_reg.busy || r_reg.interfere) begin
                        r_next.interfere = 1'b1;
                     end else if (!pwd_ok || !r_reg.mission_running_flag) begin
                        go_silent = 1'b1;
                     end else begin
                        r_next.mission_running_flag = 1'b0;
                        r_next.mission = lmc_pkg::MS_OFF;
                     end
                  end else begin
                     if (r_reg.mission_running_flag || r_reg.busy) begin
                        go_silent = 1'b1;
                     end else begin
                        r_next.busy = 1'b1;
                        r_next.forced = 1'b1;
                        r_next.sensor_start = 1'b1;
                        r_next.conv_cnt = 25'h0;
                     end
                  end
               end
            end
            default: begin
            end
         endcase
         if (go_silent) begin
            r_next.cmd = lmc_pkg::CS_SILENT;
            r_next.silent = 1'b1;
         end
      end

      // Copy authorisation: a fresh scratchpad write clears, a match sets.
      if (write_scratch_in) begin
         r_next.auth_accepted_flag = 1'b0;
      end
      if (copy_req_in && copy_match_in && !r_reg.busy &&
          !(copy_reg_page_in && r_reg.mission_running_flag)) begin
         r_next.auth_accepted_flag = 1'b1;
         r_next.copy_go = 1'b1;
      end

      r_next.regwr = !r_next.mission_running_flag;
      r_next.gs = `LMC_GS_RSVD;
      r_next.gs[`LMC_GS_MIP_BIT] = r_next.mission_running_flag;
      r_next.gs[`LMC_GS_MEMORY_CLEARED_FLAG_BIT] = r_next.memory_cleared_flag;
      r_next.gs[`LMC_GS_WAITING_FOR_ALARM_FLAG_BIT] = r_next.waiting_for_alarm_flag;
      if (r_next.interfere) begin
         r_next.gs = `LMC_ALL_ONES;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         r_reg <= '0;
         r_reg.cmd <= lmc_pkg::CS_IDLE;
         r_reg.mission <= lmc_pkg::MS_OFF;
         r_reg.gs <= `LMC_GS_RSVD;
         r_reg.regwr <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   assign general_status_out = r_reg.gs;
   assign silent_out = r_reg.silent;
   assign force_ones_out = r_reg.interfere;
   assign comm_blocked_out = r_reg.busy;
   assign reg_write_en_out = r_reg.regwr;
   assign clear_log_out = r_reg.clear_log;
   assign sensor_start_out = r_reg.sensor_start;
   assign sample_count_inc_out = r_reg.count_inc;
   assign log_first_out = r_reg.log_first;
   assign timestamp_set_out = r_reg.ts_set;
   assign temp_result_out = r_reg.temp;
   assign hum_result_out = r_reg.hum;
   assign auth_accepted_flag_out = r_reg.auth_accepted_flag;
   assign copy_go_out = r_reg.copy_go;

   silent_sticky_a: assert property (
      @(posedge clk_in) disable iff (rst_in)
      silent_out && !bus_reset_in |=> silent_out)
      else $error("silent state left without a bus reset");

   clear_sets_flag_a: assert property (
      @(posedge clk_in) disable iff (rst_in)
      clear_log_out |-> general_status_out[`LMC_GS_MEMORY_CLEARED_FLAG_BIT] && !r_reg.mission_running_flag)
      else $error("memory clear did not raise the cleared flag");

   conv_idle_only_a: assert property (
      @(posedge clk_in) disable iff (rst_in)
      $rose(r_reg.forced) |-> reg_write_en_out && $past(r_reg.cmd) == lmc_pkg::CS_DUMMY)
      else $error("forced conversion began during a mission");

   conv_bounded_a: assert property (
      @(posedge clk_in) disable iff (rst_in)
      r_reg.busy |-> r_reg.conv_cnt < 25'(CONV_CYCLES) && comm_blocked_out)
      else $error("conversion ran past its time limit");

   start_after_clear_a: assert property (
      @(posedge clk_in) disable iff (rst_in)
      $rose(r_reg.mission_running_flag) |-> $past(r_reg.memory_cleared_flag) && !reg_write_en_out)
      else $error("mission started without a cleared memory");

   copy_page_guard_a: assert property (
      @(posedge clk_in) disable iff (rst_in)
      copy_go_out |-> !($past(r_reg.mission_running_flag) && $past(copy_reg_page_in)))
      else $error("register page copy allowed during a mission");

   stop_keeps_wait_a: assert property (
      @(posedge clk_in) disable iff (rst_in)
      $fell(r_reg.mission_running_flag) |-> $stable(r_reg.waiting_for_alarm_flag) && r_reg.regwr)
      else $error("stop altered the waiting flag or page writes");

   wait_flag_shown_a: assert property (
      @(posedge clk_in) disable iff (rst_in)
      r_reg.mission == lmc_pkg::MS_ALARM |-> general_status_out[`LMC_GS_WAITING_FOR_ALARM_FLAG_BIT])
      else $error("waiting for alarm but flag reads zero");

   first_uncounted_a: assert property (
      @(posedge clk_in) disable iff (rst_in)
      log_first_out |-> !sample_count_inc_out && !timestamp_set_out)
      else $error("first alarm sample advanced the counter");

   interfere_ones_a: assert property (
      @(posedge clk_in) disable iff (rst_in)
      force_ones_out && !bus_reset_in |=> force_ones_out && general_status_out == `LMC_ALL_ONES)
      else $error("interference did not hold all-ones output");
endmodule

// ==== bench/lmc_host.sv ====
// Byte-level bus master model that faces the mission-control block.
// Assumes the clock of the block; it changes its outputs after falling edges.
`timescale 1ns/1ns
module lmc_host (
   input wire logic clk_in,
   output logic valid_out,
   output logic first_out,
   output logic [7:0] byte_out,
   output logic bus_reset_out
);
   initial begin
      valid_out = 1'b0;
      first_out = 1'b0;
      byte_out = 8'h00;
      bus_reset_out = 1'b0;
   end
   // A released data line shows the inverse of the last byte, never the byte itself.
   task automatic put(input logic first, input logic [7:0] data);
      @(negedge clk_in);
      valid_out = 1'b1;
      first_out = first;
      byte_out = data;
      @(negedge clk_in);
      valid_out = 1'b0;
      first_out = 1'b0;
      byte_out = ~data;
   endtask
   task automatic cmd(input logic [7:0] code, input logic [63:0] pwd, input logic with_pwd);
      put(1'b1, code);
      if (with_pwd) begin
         for (int k = 0; k < 8; k++) begin
            put(1'b0, pwd[8 * k +: 8]);
         end
      end
      put(1'b0, 8'hFF);
   endtask
   task automatic bus_rst();
      @(negedge clk_in);
      bus_reset_out = 1'b1;
      @(negedge clk_in);
      bus_reset_out = 1'b0;
   endtask
endmodule

// ==== bench/logger_mission_control_cmds_test.sv ====
// Self-checking testbench of the mission-control command block.
// Assumes lmc_host as bus master; shortened conversion and second counts.
`timescale 1ns/1ns
`include "lmc_defs.svh"
module logger_mission_control_cmds_test;
   localparam logic [63:0] PWD = 64'h0123456789ABCDEF;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic valid, first, bus_reset, sut = 1'b0, done = 1'b0;
   logic [7:0] fn_byte;
   logic [15:0] temp = 16'h0000, hum = 16'h0000;
   logic [7:0] gs;
   logic silent, ones, blocked, regwr, clr, sstart, cinc, tsset;
   logic [15:0] tres, hres;
   logic pw_en = 1'b1, alarm = 1'b0, copy_req = 1'b0, copy_match = 1'b0, copy_page = 1'b0;
   logic wscr = 1'b0, lfirst, auth, cgo;
   int miscompares = 0;
   int checked = 0;
   always #10 clk_in = ~clk_in;
   lmc_host i_host (.clk_in(clk_in), .valid_out(valid), .first_out(first), .byte_out(fn_byte),
      .bus_reset_out(bus_reset));
   lmc_ctrl #(.CONV_CYCLES(40), .SEC_CYCLES(20)) i_dut (.clk_in(clk_in), .rst_in(rst_in),
      .bus_reset_in(bus_reset), .fn_byte_valid_in(valid), .fn_first_in(first),
      .fn_byte_in(fn_byte), .pw_enable_in(pw_en), .pw_full_in(PWD),
      .start_on_temp_alarm_in(sut), .start_delay_in(16'h0001), .sample_period_in(16'h0064),
      .temp_alarm_in(alarm), .sensor_done_in(done), .temp_data_in(temp), .hum_data_in(hum),
      .copy_req_in(copy_req), .copy_match_in(copy_match), .copy_reg_page_in(copy_page),
      .write_scratch_in(wscr), .general_status_out(gs), .silent_out(silent),
      .force_ones_out(ones), .comm_blocked_out(blocked), .reg_write_en_out(regwr),
      .clear_log_out(clr), .sensor_start_out(sstart), .sample_count_inc_out(cinc),
      .log_first_out(lfirst), .timestamp_set_out(tsset), .temp_result_out(tres),
      .hum_result_out(hres), .auth_accepted_flag_out(auth), .copy_go_out(cgo));
   task automatic end_of_test();
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic settle();
      @(negedge clk_in);
   endtask
   task automatic t_reset_values();
      chk_word({8'h00, gs}, 16'h00E5);
      chk_bit(regwr, 1'b1);
      chk_bit(silent, 1'b0);
   endtask
   // Starting before any clear must be refused with silence.
   task automatic t_start_uncleared();
      i_host.cmd(`LMC_CMD_START, PWD, 1'b1);
      settle();
      chk_bit(silent, 1'b1);
      chk_bit(gs[`LMC_GS_MIP_BIT], 1'b0);
      i_host.bus_rst();
      settle();
      chk_bit(silent, 1'b0);
   endtask
   task automatic t_clear_ok();
      i_host.cmd(`LMC_CMD_CLEAR, PWD, 1'b1);
      chk_bit(clr, 1'b1);
      chk_bit(gs[`LMC_GS_MEMORY_CLEARED_FLAG_BIT], 1'b1);
      chk_bit(gs[`LMC_GS_WAITING_FOR_ALARM_FLAG_BIT], 1'b0);
      chk_bit(silent, 1'b0);
      i_host.bus_rst();
   endtask
   task automatic t_mission();
      int n;
      sut = 1'b0;
      i_host.cmd(`LMC_CMD_START, PWD, 1'b1);
      settle();
      chk_bit(gs[`LMC_GS_MIP_BIT], 1'b1);
      chk_bit(regwr, 1'b0);
      i_host.bus_rst();
      for (n = 0; n < 200 && tsset !== 1'b1; n++) begin
         settle();
      end
      if (n == 200) begin
         miscompares++;
         end_of_test();
      end
      chk_bit(n > 20, 1'b1);
      chk_bit(cinc, 1'b1);
      chk_bit(sstart, 1'b1);
      i_host.cmd(`LMC_CMD_STOP, PWD, 1'b1);
      settle();
      chk_bit(ones, 1'b1);
      chk_word({8'h00, gs}, 16'h00FF);
      done = 1'b1;
      settle();
      done = 1'b0;
      i_host.bus_rst();
      settle();
      chk_bit(ones, 1'b0);
      chk_bit(gs[`LMC_GS_MIP_BIT], 1'b1);
      i_host.cmd(`LMC_CMD_CONV, 64'h0, 1'b0);
      chk_bit(sstart, 1'b0);
      settle();
      chk_bit(silent, 1'b1);
      i_host.bus_rst();
      i_host.cmd(`LMC_CMD_CLEAR, PWD, 1'b1);
      settle();
      chk_bit(silent, 1'b1);
      i_host.bus_rst();
      i_host.cmd(`LMC_CMD_START, PWD, 1'b1);
      settle();
      chk_bit(silent, 1'b1);
      i_host.bus_rst();
   endtask
   task automatic t_stop();
      i_host.cmd(`LMC_CMD_STOP, ~PWD, 1'b1);
      settle();
      chk_bit(silent, 1'b1);
      chk_bit(gs[`LMC_GS_MIP_BIT], 1'b1);
      i_host.bus_rst();
      i_host.cmd(`LMC_CMD_STOP, PWD, 1'b1);
      settle();
      chk_bit(gs[`LMC_GS_MIP_BIT], 1'b0);
      chk_bit(regwr, 1'b1);
      i_host.bus_rst();
      i_host.cmd(`LMC_CMD_STOP, PWD, 1'b1);
      settle();
      chk_bit(silent, 1'b1);
      i_host.bus_rst();
   endtask
   task automatic t_alarm_wait();
      t_clear_ok();
      sut = 1'b1;
      i_host.cmd(`LMC_CMD_START, PWD, 1'b1);
      settle();
      chk_bit(gs[`LMC_GS_WAITING_FOR_ALARM_FLAG_BIT], 1'b1);
      chk_bit(cinc, 1'b0);
      i_host.bus_rst();
      i_host.cmd(`LMC_CMD_STOP, PWD, 1'b1);
      settle();
      chk_bit(gs[`LMC_GS_MIP_BIT], 1'b0);
      chk_bit(gs[`LMC_GS_WAITING_FOR_ALARM_FLAG_BIT], 1'b1);
      i_host.bus_rst();
   endtask
   task automatic t_clear_bad();
      i_host.cmd(`LMC_CMD_CLEAR, ~PWD, 1'b1);
      chk_bit(clr, 1'b0);
      settle();
      chk_bit(silent, 1'b1);
      i_host.bus_rst();
   endtask
   task automatic t_forced_conv();
      i_host.cmd(`LMC_CMD_CONV, 64'h0, 1'b0);
      chk_bit(sstart, 1'b1);
      settle();
      chk_bit(blocked, 1'b1);
      temp = 16'hA5C3;
      hum = 16'h3C5A;
      done = 1'b1;
      settle();
      done = 1'b0;
      settle();
      chk_word(tres, 16'hA5C3);
      chk_word(hres, 16'h3C5A);
      chk_bit(blocked, 1'b0);
      chk_bit(ones, 1'b1);
      i_host.bus_rst();
   endtask
   // A matching copy sets the flag; a scratchpad write clears it again.
   task automatic t_copy();
      copy_match = 1'b1;
      copy_req = 1'b1;
      settle();
      copy_req = 1'b0;
      chk_bit(cgo, 1'b1);
      chk_bit(auth, 1'b1);
      wscr = 1'b1;
      copy_match = 1'b0;
      copy_req = 1'b1;
      settle();
      wscr = 1'b0;
      copy_req = 1'b0;
      chk_bit(cgo, 1'b0);
      chk_bit(auth, 1'b0);
   endtask
   // Alarm start with passwords disabled; the first sample is uncounted.
   task automatic t_alarm_start();
      int n;
      t_clear_ok();
      sut = 1'b1;
      pw_en = 1'b0;
      i_host.cmd(`LMC_CMD_START, ~PWD, 1'b1);
      pw_en = 1'b1;
      i_host.bus_rst();
      chk_bit(gs[`LMC_GS_MIP_BIT], 1'b1);
      chk_bit(gs[`LMC_GS_WAITING_FOR_ALARM_FLAG_BIT], 1'b1);
      copy_page = 1'b1;
      copy_match = 1'b1;
      copy_req = 1'b1;
      settle();
      copy_req = 1'b0;
      chk_bit(cgo, 1'b0);
      chk_bit(auth, 1'b0);
      alarm = 1'b1;
      settle();
      chk_bit(lfirst, 1'b1);
      chk_bit(cinc, 1'b0);
      chk_bit(sstart, 1'b1);
      for (n = 0; n < 2100 && tsset !== 1'b1; n++) begin
         settle();
      end
      if (n == 2100) begin
         miscompares++;
         end_of_test();
      end
      chk_bit(n > 1980 && n <= 2000, 1'b1);
      chk_bit(cinc, 1'b1);
   endtask
   initial begin
      repeat (8) @(negedge clk_in);
      rst_in = 1'b0;
      t_reset_values();
      t_start_uncleared();
      t_clear_ok();
      t_mission();
      t_stop();
      t_alarm_wait();
      t_clear_bad();
      t_forced_conv();
      t_copy();
      t_alarm_start();
      end_of_test();
   end
endmodule
